// *** hw/wsst_defines.vh ***
`ifndef WSST_DEFINES_VH
`define WSST_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WSST_ADDR_SELECT 8'h27
`define WSST_ADDR_TIMEBASE 8'h28
`define WSST_ADDR_PERIOD 8'h29

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WSST_RST_SELECT 16'h0101
`define WSST_RST_TIMEBASE 16'h0111
`define WSST_RST_PERIOD 16'h8000

// ----------------------------------------------------------------
// Field positions in the waveform select register
// ----------------------------------------------------------------
`define WSST_CH2_GEN 13:12
`define WSST_CH4_FORCE 11
`define WSST_CH2_SUM 10
`define WSST_CH2_SRC 9:8
`define WSST_CH1_GEN 5:4
`define WSST_CH3_FORCE 3
`define WSST_CH1_SUM 2
`define WSST_CH1_SRC 1:0

// ----------------------------------------------------------------
// Field positions in the timebase register
// ----------------------------------------------------------------
`define WSST_HOLD 11:8
`define WSST_PERIOD_UNIT 7:4
`define WSST_DELAY_UNIT 3:0

// ----------------------------------------------------------------
// Source and generator codes
// ----------------------------------------------------------------
`define WSST_SRC_RAM 2'h0
`define WSST_SRC_GEN 2'h1
`define WSST_SRC_GATED 2'h2
`define WSST_SRC_AM 2'h3
`define WSST_GEN_CONST 2'h0
`define WSST_GEN_SAW 2'h1
`define WSST_GEN_PRNG 2'h2
`define WSST_GEN_DDS 2'h3

// ----------------------------------------------------------------
// Sample limits
// ----------------------------------------------------------------
`define WSST_SAMPLE_MAX 12'h7FF
`define WSST_SAMPLE_MIN 12'h800

`endif

// *** hw/wsst_top.v ***
// What this block does
// - Source code 0 plays the channel from pattern RAM, stepping from first to last address.
// - Source code 1 passes the generator straight out; code 2 passes it only inside the gate.
// - Source code 3 outputs the generator scaled by the RAM sample as amplitude modulation.
// - The generator select picks constant, sawtooth, pseudorandom or sine synth output.
// - A force bit replaces channel 4 or channel 3 output with its constant value.
// - The channel 2 sum bit outputs channel 2 plus channel 4 on channel 2.
// - Channel 3 and channel 4 outputs never carry the summation.
// - The channel 1 sum bit puts channel 1 plus channel 3 on channel 1, else both run alone.
// - Each RAM sample is held N clocks, where a hold field of 0 means 16.
// - The RAM read address advances once per hold interval in source codes 0 and 3; codes 1 and 2 hold it at the first address.
// - The period unit field gives clocks per period unit, 1 to 15, with 0 meaning 16.
// - The delay unit field gives clocks per gate delay unit, 1 to 15, with 0 meaning 16.
// - A pattern lasts period value times period unit clocks; the period resets to 0x8000.
// - Hold and both unit fields reset to 1 and both source fields reset to code 1, direct generator output.
// - Constants are 12-bit two's complement codes from 0x800 to 0x7FF.
`timescale 1ns/1ps
`include "wsst_defines.vh"

module wsst_top (
   input wire sys_clk,
   input wire rst,
   input wire reg_wr_en,
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wr_data,
   output wire [15:0] reg_rd_data,
   input wire [11:0] ch1_constant_value,
   input wire [11:0] ch2_constant_value,
   input wire [11:0] ch3_constant_value,
   input wire [11:0] ch4_constant_value,
   input wire [11:0] ch1_saw_sample,
   input wire [11:0] ch2_saw_sample,
   input wire [11:0] ch1_sine_synth,
   input wire [11:0] ch2_sine_synth,
   input wire [11:0] prng_sample,
   input wire [11:0] ch3_wave,
   input wire [11:0] ch4_wave,
   input wire [11:0] ch1_ram_first_address,
   input wire [11:0] ch1_ram_last_address,
   input wire [11:0] ch2_ram_first_address,
   input wire [11:0] ch2_ram_last_address,
   input wire [15:0] ch1_gate_delay,
   input wire [15:0] ch2_gate_delay,
   input wire [11:0] ch1_ram_data,
   input wire [11:0] ch2_ram_data,
   output wire [11:0] ch1_ram_addr,
   output wire [11:0] ch2_ram_addr,
   output wire pattern_start,
   output wire [11:0] ch1_out,
   output wire [11:0] ch2_out,
   output wire [11:0] ch3_out,
   output wire [11:0] ch4_out
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [15:0] select_reg;
   reg [15:0] timebase_reg;
   reg [15:0] period_reg;
   reg [15:0] rd_data_reg;
   reg [15:0] rd_data_next;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         select_reg <= `WSST_RST_SELECT;
         timebase_reg <= `WSST_RST_TIMEBASE;
         period_reg <= `WSST_RST_PERIOD;
      end else if (reg_wr_en) begin
         // Whole words are stored, so reserved bits read back as written.
         if (reg_addr == `WSST_ADDR_SELECT) begin
            select_reg <= reg_wr_data;
         end
         if (reg_addr == `WSST_ADDR_TIMEBASE) begin
            timebase_reg <= reg_wr_data;
         end
         if (reg_addr == `WSST_ADDR_PERIOD) begin
            period_reg <= reg_wr_data;
         end
      end
   end

   always @* begin
      case (reg_addr)
         `WSST_ADDR_SELECT: rd_data_next = select_reg;
         `WSST_ADDR_TIMEBASE: rd_data_next = timebase_reg;
         `WSST_ADDR_PERIOD: rd_data_next = period_reg;
         default: rd_data_next = 16'h0000;
      endcase
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_data_reg <= 16'h0000;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign reg_rd_data = rd_data_reg;

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   wire hold_tick;
   wire period_tick;
   wire delay_tick;
   wire pattern_end;
   reg [15:0] unit_count_reg;
   reg start_reg;

   wsst_unit_tick u_hold (
      .sys_clk(sys_clk),
      .rst(rst),
      .restart(1'b0),
      .unit_size(timebase_reg[`WSST_HOLD]),
      .tick(hold_tick)
   );

   wsst_unit_tick u_period (
      .sys_clk(sys_clk),
      .rst(rst),
      .restart(1'b0),
      .unit_size(timebase_reg[`WSST_PERIOD_UNIT]),
      .tick(period_tick)
   );

   wsst_unit_tick u_delay (
      .sys_clk(sys_clk),
      .rst(rst),
      .restart(pattern_end),
      .unit_size(timebase_reg[`WSST_DELAY_UNIT]),
      .tick(delay_tick)
   );

   // The pattern ends after period value units; a value of 0 acts as 1.
   assign pattern_end = period_tick && (unit_count_reg + 16'h0001 >= period_reg);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         unit_count_reg <= 16'h0000;
         start_reg <= 1'b0;
      end else begin
         start_reg <= pattern_end;
         if (pattern_end) begin
            unit_count_reg <= 16'h0000;
         end else if (period_tick) begin
            unit_count_reg <= unit_count_reg + 16'h0001;
         end
      end
   end

   assign pattern_start = start_reg;

   // ----------------------------------------------------------------
   // Channel 1 and 2 sources
   // ----------------------------------------------------------------
   wire [23:0] const_v = {ch2_constant_value, ch1_constant_value};
   wire [23:0] saw_v = {ch2_saw_sample, ch1_saw_sample};
   wire [23:0] dds_v = {ch2_sine_synth, ch1_sine_synth};
   wire [23:0] first_v = {ch2_ram_first_address, ch1_ram_first_address};
   wire [23:0] last_v = {ch2_ram_last_address, ch1_ram_last_address};
   wire [31:0] gdelay_v = {ch2_gate_delay, ch1_gate_delay};
   wire [23:0] ram_v = {ch2_ram_data, ch1_ram_data};
   wire [3:0] src_v = {select_reg[`WSST_CH2_SRC], select_reg[`WSST_CH1_SRC]};
   wire [3:0] gen_sel_v = {select_reg[`WSST_CH2_GEN], select_reg[`WSST_CH1_GEN]};
   wire [23:0] pre_v;
   wire [23:0] addr_v;

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_ch
         reg [11:0] addr_reg;
         reg [15:0] delay_count_reg;
         reg [11:0] gen;
         reg [11:0] pre;
         wire [1:0] src = src_v[i*2+:2];
         wire signed [23:0] product;
         wire gate_open;

         always @* begin
            case (gen_sel_v[i*2+:2])
               `WSST_GEN_CONST: gen = const_v[i*12+:12];
               `WSST_GEN_SAW: gen = saw_v[i*12+:12];
               `WSST_GEN_PRNG: gen = prng_sample;
               default: gen = dds_v[i*12+:12];
            endcase
         end

         assign product = $signed(gen) * $signed(ram_v[i*12+:12]);
         assign gate_open = (delay_count_reg >= gdelay_v[i*16+:16]);

         always @* begin
            case (src)
               `WSST_SRC_RAM: pre = ram_v[i*12+:12];
               `WSST_SRC_GEN: pre = gen;
               `WSST_SRC_GATED: pre = gate_open ? gen : 12'h000;
               default: pre = product[22:11];
            endcase
         end

         assign pre_v[i*12+:12] = pre;
         assign addr_v[i*12+:12] = addr_reg;

         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               addr_reg <= 12'h000;
               delay_count_reg <= 16'h0000;
            end else begin
               if (src == `WSST_SRC_GEN || src == `WSST_SRC_GATED) begin
                  addr_reg <= first_v[i*12+:12];
               end else if (hold_tick) begin
                  if (addr_reg == last_v[i*12+:12]) begin
                     addr_reg <= first_v[i*12+:12];
                  end else begin
                     addr_reg <= addr_reg + 12'h001;
                  end
               end
               if (pattern_end) begin
                  delay_count_reg <= 16'h0000;
               end else if (delay_tick && delay_count_reg != 16'hFFFF) begin
                  delay_count_reg <= delay_count_reg + 16'h0001;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Forcing, summing and output stage
   // ----------------------------------------------------------------
   function [11:0] sat_add;
      input [11:0] a;
      input [11:0] b;
      reg [12:0] s;
      begin
         s = {a[11], a} + {b[11], b};
         if (s[12] != s[11]) begin
            sat_add = s[12] ? `WSST_SAMPLE_MIN : `WSST_SAMPLE_MAX;
         end else begin
            sat_add = s[11:0];
         end
      end
   endfunction

   wire [11:0] ch3_eff = select_reg[`WSST_CH3_FORCE] ? ch3_constant_value : ch3_wave;
   wire [11:0] ch4_eff = select_reg[`WSST_CH4_FORCE] ? ch4_constant_value : ch4_wave;
   reg [11:0] ch1_out_reg;
   reg [11:0] ch2_out_reg;
   reg [11:0] ch3_out_reg;
   reg [11:0] ch4_out_reg;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ch1_out_reg <= 12'h000;
         ch2_out_reg <= 12'h000;
         ch3_out_reg <= 12'h000;
         ch4_out_reg <= 12'h000;
      end else begin
         if (select_reg[`WSST_CH1_SUM]) begin
            ch1_out_reg <= sat_add(pre_v[11:0], ch3_eff);
         end else begin
            ch1_out_reg <= pre_v[11:0];
         end
         if (select_reg[`WSST_CH2_SUM]) begin
            ch2_out_reg <= sat_add(pre_v[23:12], ch4_eff);
         end else begin
            ch2_out_reg <= pre_v[23:12];
         end
         ch3_out_reg <= ch3_eff;
         ch4_out_reg <= ch4_eff;
      end
   end

   assign ch1_out = ch1_out_reg;
   assign ch2_out = ch2_out_reg;
   assign ch3_out = ch3_out_reg;
   assign ch4_out = ch4_out_reg;
   assign ch1_ram_addr = addr_v[11:0];
   assign ch2_ram_addr = addr_v[23:12];
endmodule

// *** hw/wsst_unit_tick.v ***
`timescale 1ns/1ps

// Divides the clock by N from a 4-bit field, where 0 means 16.
module wsst_unit_tick (
   input wire sys_clk,
   input wire rst,
   input wire restart,
   input wire [3:0] unit_size,
   output wire tick
);
   reg [4:0] count_reg;
   wire [4:0] last_count;

   assign last_count = (unit_size == 4'h0) ? 5'h0F : {1'b0, unit_size} - 5'h01;
   assign tick = (count_reg >= last_count);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_reg <= 5'h00;
      end else if (restart || tick) begin
         count_reg <= 5'h00;
      end else begin
         count_reg <= count_reg + 5'h01;
      end
   end
endmodule

// *** verif/tb_waveform_source_select_timebase.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Bench for the select and timebase block.
// ----------------------------------------
module tb_waveform_source_select_timebase;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg we = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [15:0] wd = 16'h0000;
   reg [11:0] k1 = 12'h111, k2 = 12'h211, k3 = 12'h000, k4 = 12'h000, s1 = 12'h122;
   reg [11:0] s2 = 12'h222, d1 = 12'h144, d2 = 12'h244, pr = 12'h133, w3 = 12'h0A0;
   reg [11:0] w4 = 12'h0B0, f1 = 12'h000, l1 = 12'h000, r1 = 12'h000;
   reg [11:0] f2 = 12'h000, l2 = 12'h000, r2 = 12'h000;
   reg [15:0] g1 = 16'h0000, g2 = 16'h0000;
   wire [15:0] rd;
   wire [11:0] a1, a2, o1, o2, o3, o4;
   wire ps;
   integer n_fail = 0;
   integer tests_run = 0;

   wsst_top DUT (
      .sys_clk(sys_clk), .rst(rst), .reg_wr_en(we), .reg_addr(addr), .reg_wr_data(wd),
      .reg_rd_data(rd), .ch1_constant_value(k1), .ch2_constant_value(k2),
      .ch3_constant_value(k3), .ch4_constant_value(k4), .ch1_saw_sample(s1),
      .ch2_saw_sample(s2), .ch1_sine_synth(d1), .ch2_sine_synth(d2), .prng_sample(pr),
      .ch3_wave(w3), .ch4_wave(w4), .ch1_ram_first_address(f1), .ch1_ram_last_address(l1),
      .ch2_ram_first_address(f2), .ch2_ram_last_address(l2), .ch1_gate_delay(g1),
      .ch2_gate_delay(g2), .ch1_ram_data(r1), .ch2_ram_data(r2), .ch1_ram_addr(a1),
      .ch2_ram_addr(a2), .pattern_start(ps), .ch1_out(o1), .ch2_out(o2), .ch3_out(o3),
      .ch4_out(o4)
   );

   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge sys_clk);
         we <= 1'b1;
         addr <= a;
         wd <= d;
         @(posedge sys_clk);
         we <= 1'b0;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task rdc(input [7:0] a, input [15:0] e);
      begin
         @(posedge sys_clk);
         addr <= a;
         tick(2);
         chk("reg_rd_data", e, rd);
      end
   endtask
   task cnt(output integer c);
      begin
         c = 0;
         tick(8);
         repeat (12) begin
            tick(1);
            if (o2 === k2) c = c + 1;
         end
      end
   endtask

   task t_regs;
      begin
         rdc(8'h27, 16'h0101);
         rdc(8'h28, 16'h0111);
         rdc(8'h29, 16'h8000);
         wr(8'h28, 16'hF111);
         rdc(8'h28, 16'hF111);
         rdc(8'h2A, 16'h0000);
         $display("register test done");
      end
   endtask
   task t_gen;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            wr(8'h27, {2'h0, i[1:0], 4'h1, 2'h0, i[1:0], 4'h1});
            {s1, s2, d1, d2, pr} <= {s1 + 12'h010, s2 + 12'h010, d1 + 12'h010, d2 + 12'h010, pr};
            tick(2);
            chk("ch1_out", i == 0 ? k1 : i == 1 ? s1 : i == 2 ? pr : d1, o1);
            chk("ch2_out", i == 0 ? k2 : i == 1 ? s2 : i == 2 ? pr : d2, o2);
         end
         $display("generator test done");
      end
   endtask
   task t_sum;
      begin
         wr(8'h27, 16'h0505);
         k1 <= 12'h700;
         w3 <= 12'h100;
         k2 <= 12'h900;
         w4 <= 12'h800;
         tick(2);
         chk("ch1_out", 16'h07FF, o1);
         chk("ch2_out", 16'h0800, o2);
         chk("ch3_out", 16'h0100, o3);
         chk("ch4_out", 16'h0800, o4);
         wr(8'h27, 16'h0D0D);
         k3 <= 12'h005;
         k4 <= 12'h7FF;
         tick(2);
         chk("ch1_out", 16'h0705, o1);
         chk("ch2_out", 16'h00FF, o2);
         chk("ch3_out", 16'h0005, o3);
         chk("ch4_out", 16'h07FF, o4);
         wr(8'h27, 16'h0101);
         tick(2);
         chk("ch1_out", 16'h0700, o1);
         $display("sum test done");
      end
   endtask
   task t_ram;
      integer j;
      reg [11:0] a0;
      begin
         wr(8'h28, 16'h0211);
         f1 <= 12'h005;
         l1 <= 12'h007;
         r1 <= 12'h123;
         f2 <= 12'h009;
         l2 <= 12'h009;
         r2 <= 12'h2AB;
         wr(8'h27, 16'h0000);
         tick(4);
         chk("ch2_ram_addr", 16'h0009, a2);
         chk("ch2_out", 16'h02AB, o2);
         a0 = a1;
         j = 0;
         while (a1 === a0 && j < 40) begin
            tick(1);
            j = j + 1;
         end
         a0 = a1;
         for (j = 1; j < 8; j = j + 1) begin
            tick(1);
            chk("ch1_ram_addr", 12'h005 + (a0 - 12'h005 + j / 2) % 3, a1);
            chk("ch1_out", 16'h0123, o1);
         end
         wr(8'h27, 16'h0303);
         k1 <= 12'h400;
         r1 <= 12'h400;
         k2 <= 12'hC00;
         r2 <= 12'h400;
         tick(2);
         chk("ch1_out", 16'h0200, o1);
         chk("ch2_out", 16'h0E00, o2);
         $display("ram test done");
      end
   endtask
   task t_gate;
      integer j;
      integer c;
      begin
         wr(8'h28, 16'h0121);
         wr(8'h29, 16'h0003);
         for (c = 0; c < 2; c = c + 1) begin
            j = 0;
            tick(1);
            while (ps !== 1'b1 && j < 40) begin
               tick(1);
               j = j + 1;
            end
         end
         chk("pattern length", 16'd6, j + 1);
         wr(8'h27, 16'h0201);
         k2 <= 12'h333;
         g2 <= 16'hFFFF;
         cnt(c);
         chk("open cycles", 16'd0, c);
         @(posedge sys_clk);
         g2 <= 16'h0000;
         cnt(c);
         chk("open cycles", 16'd12, c);
         wr(8'h28, 16'h0120);
         g2 <= 16'h0001;
         cnt(c);
         chk("open cycles", 16'd0, c);
         wr(8'h28, 16'h0121);
         cnt(c);
         chk("open cycles", 16'd10, c);
         $display("gate test done");
      end
   endtask

   task conclude;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs;
      t_gen;
      t_sum;
      t_ram;
      t_gate;
      conclude;
   end
   initial begin
      #1000000;
      n_fail = n_fail + 1;
      $display("Error watchdog expired");
      conclude;
   end
endmodule

// *** verif/wsst_assertions.sv ***
`timescale 1ns/1ps
`include "wsst_defines.vh"

// ----------------------------------------
// Channel output checks.
// ----------------------------------------
module wsst_assertions (
   input wire sys_clk,
   input wire rst,
   input wire reg_wr_en,
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wr_data,
   input wire [11:0] ch1_constant_value,
   input wire [11:0] ch2_constant_value,
   input wire [11:0] ch3_constant_value,
   input wire [11:0] ch4_constant_value,
   input wire [11:0] ch3_wave,
   input wire [11:0] ch4_wave,
   input wire [11:0] ch1_out,
   input wire [11:0] ch2_out,
   input wire [11:0] ch3_out,
   input wire [11:0] ch4_out
);
   reg [15:0] sel_reg;
   wire [11:0] c3 = sel_reg[3] ? ch3_constant_value : ch3_wave;
   wire [11:0] c4 = sel_reg[11] ? ch4_constant_value : ch4_wave;
   wire [12:0] s1 = {ch1_constant_value[11], ch1_constant_value} + {c3[11], c3};
   wire [12:0] s2 = {ch2_constant_value[11], ch2_constant_value} + {c4[11], c4};
   wire [11:0] e1 = (s1[12] == s1[11]) ? s1[11:0] : {s1[12], {11{~s1[12]}}};
   wire [11:0] e2 = (s2[12] == s2[11]) ? s2[11:0] : {s2[12], {11{~s2[12]}}};
   wire g1 = sel_reg[1:0] == 2'h1 && sel_reg[5:4] == 2'h0;
   wire g2 = sel_reg[9:8] == 2'h1 && sel_reg[13:12] == 2'h0;

   // Shadow of the waveform select register.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_reg <= `WSST_RST_SELECT;
      end else if (reg_wr_en && reg_addr == `WSST_ADDR_SELECT) begin
         sel_reg <= reg_wr_data;
      end
   end

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_ch3_forced: assert property (sel_reg[3] |=> ch3_out == $past(ch3_constant_value))
      else $error("ch3 not forced");
   chk_ch4_forced: assert property (sel_reg[11]
      |=> ch4_out == $past(ch4_constant_value))
      else $error("ch4 not forced");
   chk_ch3_alone: assert property (!sel_reg[3] |=> ch3_out == $past(ch3_wave))
      else $error("ch3 altered");
   chk_ch4_alone: assert property (!sel_reg[11] |=> ch4_out == $past(ch4_wave))
      else $error("ch4 altered");
   chk_ch1_const: assert property (g1 && !sel_reg[2]
      |=> ch1_out == $past(ch1_constant_value))
      else $error("ch1 constant wrong");
   chk_ch2_const: assert property (g2 && !sel_reg[10]
      |=> ch2_out == $past(ch2_constant_value))
      else $error("ch2 constant wrong");
   chk_ch1_sum: assert property (g1 && sel_reg[2] |=> ch1_out == $past(e1))
      else $error("ch1 sum wrong");
   chk_ch2_sum: assert property (g2 && sel_reg[10] |=> ch2_out == $past(e2))
      else $error("ch2 sum wrong");
endmodule

bind wsst_top wsst_assertions chk (
   .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
   .reg_wr_data(reg_wr_data), .ch1_constant_value(ch1_constant_value),
   .ch2_constant_value(ch2_constant_value), .ch3_constant_value(ch3_constant_value),
   .ch4_constant_value(ch4_constant_value), .ch3_wave(ch3_wave), .ch4_wave(ch4_wave),
   .ch1_out(ch1_out), .ch2_out(ch2_out), .ch3_out(ch3_out), .ch4_out(ch4_out)
);
